// >>> lvmc_map.svh
// register offsets, field positions, reset values and timing counts
// Function
// RULE1 - warning flag (bit 7, reg a) sets on supply below warning trip
// RULE2 - writing warning ack clears flag only if no warning present
// RULE3 - warning irq enable (bit 5) with flag set raises interrupt
// RULE4 - write-once detect-reset enable forces reset on detect event
// RULE5 - detect-in-stop bit keeps detection running in stop mode
// RULE6 - write-once detect enable gates detect logic and qualifiers
// RULE7 - reference buffer enable (bit 0) turns the bandgap buffer on
// RULE8 - write-once detect select picks detect trip and warning range
// RULE9 - warning select with detect select picks one of four trips
// RULE10 - deep stop recovered flag reads 1 after leaving deep stop
// RULE11 - writing 1 to deep stop ack clears the recovered flag
// RULE12 - write-once stop depth: 0 shallow retaining, 1 deep stop
// RULE13 - write-once bits take only the first write after reset
// RULE14 - detect select lock re-armed only by power-on reset
// RULE15 - deep stop with detect-in-stop set enters shallow stop; code does so only if det_en is also set
// RULE16 - plain enables reset to 0; ack bits always read 0
`ifndef LVMC_MAP_SVH
`define LVMC_MAP_SVH
`define LVMC_ADDR_W 4
`define LVMC_OFS_CTRL_A 4'h0
`define LVMC_OFS_CTRL_B 4'h1
`define LVMC_OFS_IRQ_STAT 4'h2
`define LVMC_OFS_IRQ_MASK 4'h3
`define LVMC_A_WARN_FLAG 7
`define LVMC_A_WARN_ACK 6
`define LVMC_A_WARN_IE 5
`define LVMC_A_RST_EN 4
`define LVMC_A_STOP_EN 3
`define LVMC_A_DET_EN 2
`define LVMC_A_REF_BUF 0
`define LVMC_B_DET_SEL 5
`define LVMC_B_WARN_SEL 4
`define LVMC_B_DEEP_FLAG 3
`define LVMC_B_DEEP_ACK 2
`define LVMC_B_DEPTH 0
`define LVMC_IRQ_WARN 0
`define LVMC_IRQ_DETECT 1
`define LVMC_IRQ_DEEP 2
`define LVMC_RST_VAL 1'b0
`define LVMC_SYNC_STAGES 3
`endif

// >>> lvmc_pkg.sv
// types shared by the low voltage monitor control block
package lvmc_pkg;
    typedef logic [7:0] lvmc_byte_t;
    typedef enum logic [1:0] {LVMC_RUN, LVMC_SHALLOW, LVMC_DEEP}
        lvmc_mode_t;
endpackage : lvmc_pkg

// >>> lvmc_sync.sv
// three stage synchroniser with agreement on stages two and three
`timescale 1ns/10ps
module lvmc_sync
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic [2:0] sh;
        logic out;
    } lvmc_sync_st_t;
    lvmc_sync_st_t s_q;
    lvmc_sync_st_t s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.sh = {s_q.sh[1:0], din};
        // first stage only feeds the second
        if (s_q.sh[1] == s_q.sh[2])
        begin
            s_d.out = s_q.sh[2];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.out;
endmodule : lvmc_sync

// >>> lvmc_ctrl.sv
// low voltage monitor control and stop depth selection
`timescale 1ns/10ps
`include "lvmc_map.svh"
module lvmc_ctrl
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic por_event,
    input wire logic [`LVMC_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output lvmc_pkg::lvmc_byte_t reg_rdata,
    input wire logic warn_below,
    input wire logic detect_below,
    input wire logic stop_req,
    input wire logic wake_req,
    output logic irq,
    output logic detect_reset_req,
    output logic detect_active,
    output logic detect_trip_select,
    output logic warning_trip_select,
    output logic reference_buffer_en,
    output logic stop_shallow,
    output logic stop_deep
);
    import lvmc_pkg::*;

    typedef struct packed {
        logic warn_flag;
        logic warn_ie;
        logic rst_en;
        logic stop_en;
        logic det_en;
        logic ref_buf;
        logic det_sel;
        logic warn_sel;
        logic deep_flag;
        logic depth;
        logic lock_a;
        logic lock_b;
        logic lock_det_sel;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        lvmc_mode_t mode;
        lvmc_byte_t rdata;
        logic irq;
        logic rst_req;
        logic det_act;
        logic stop_sh;
        logic stop_dp;
    } lvmc_st_t;

    lvmc_st_t s_q;
    lvmc_st_t s_d;
    logic warn_s;
    logic det_s;
    logic por_lock_q;
    logic por_sel_q;

    lvmc_sync u_sync_warn
    (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .din(warn_below),
        .dout(warn_s)
    );

    lvmc_sync u_sync_det
    (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .din(detect_below),
        .dout(det_s)
    );

    logic wr_a;
    logic wr_b;
    logic det_ev;
    logic [7:0] rd_mux;
    assign wr_a = reg_wr && reg_addr == `LVMC_OFS_CTRL_A;
    assign wr_b = reg_wr && reg_addr == `LVMC_OFS_CTRL_B;
    // detection runs in run mode, and in stop only when allowed
    assign det_ev = det_s && s_q.det_en && //RULE6
        (s_q.mode == LVMC_RUN || s_q.stop_en); //RULE5

    always_comb
    begin
        rd_mux = 8'h00;
        unique case (reg_addr)
            `LVMC_OFS_CTRL_A:
            begin
                rd_mux[`LVMC_A_WARN_FLAG] = s_q.warn_flag;
                rd_mux[`LVMC_A_WARN_IE] = s_q.warn_ie;
                rd_mux[`LVMC_A_RST_EN] = s_q.rst_en;
                rd_mux[`LVMC_A_STOP_EN] = s_q.stop_en;
                rd_mux[`LVMC_A_DET_EN] = s_q.det_en;
                rd_mux[`LVMC_A_REF_BUF] = s_q.ref_buf; // ack reads 0 RULE16
            end
            `LVMC_OFS_CTRL_B:
            begin
                rd_mux[`LVMC_B_DET_SEL] = por_sel_q;
                rd_mux[`LVMC_B_WARN_SEL] = s_q.warn_sel;
                rd_mux[`LVMC_B_DEEP_FLAG] = s_q.deep_flag; //RULE10
                rd_mux[`LVMC_B_DEPTH] = s_q.depth;
            end
            `LVMC_OFS_IRQ_STAT: rd_mux[2:0] = s_q.irq_stat;
            `LVMC_OFS_IRQ_MASK: rd_mux[2:0] = s_q.irq_mask;
            default: rd_mux = 8'h00;
        endcase
    end

    always_comb
    begin
        s_d = s_q;
        s_d.rdata = reg_rd ? rd_mux : 8'h00;
        if (wr_a)
        begin
            s_d.warn_ie = reg_wdata[`LVMC_A_WARN_IE];
            s_d.stop_en = reg_wdata[`LVMC_A_STOP_EN];
            s_d.ref_buf = reg_wdata[`LVMC_A_REF_BUF]; //RULE7
            if (!s_q.lock_a) //RULE13
            begin
                s_d.rst_en = reg_wdata[`LVMC_A_RST_EN]; //RULE4
                s_d.det_en = reg_wdata[`LVMC_A_DET_EN]; //RULE6
                s_d.lock_a = 1'b1;
            end
            if (reg_wdata[`LVMC_A_WARN_ACK] && !warn_s)
            begin
                s_d.warn_flag = 1'b0; //RULE2
            end
        end
        if (wr_b)
        begin
            s_d.warn_sel = reg_wdata[`LVMC_B_WARN_SEL]; //RULE9
            if (!s_q.lock_b) //RULE13
            begin
                s_d.depth = reg_wdata[`LVMC_B_DEPTH]; //RULE12
                s_d.lock_b = 1'b1;
            end
            if (reg_wdata[`LVMC_B_DEEP_ACK])
            begin
                s_d.deep_flag = 1'b0; //RULE11
            end
        end
        // hardware set beats software clear
        if (warn_s)
        begin
            s_d.warn_flag = 1'b1; //RULE1
        end
        s_d.irq_stat[`LVMC_IRQ_WARN] = s_q.irq_stat[`LVMC_IRQ_WARN] |
            (warn_s & ~s_q.warn_flag);
        s_d.irq_stat[`LVMC_IRQ_DETECT] = s_q.irq_stat[`LVMC_IRQ_DETECT] |
            det_ev;
        if (reg_wr && reg_addr == `LVMC_OFS_IRQ_STAT)
        begin
            s_d.irq_stat = s_d.irq_stat & ~reg_wdata[2:0] |
                {1'b0, det_ev, warn_s & ~s_q.warn_flag};
        end
        if (reg_wr && reg_addr == `LVMC_OFS_IRQ_MASK)
        begin
            s_d.irq_mask = reg_wdata[2:0];
        end
        unique case (s_q.mode)
            LVMC_RUN:
                if (stop_req)
                begin
                    // deep stop would kill the detector
                    s_d.mode = (s_q.depth && !(s_q.det_en && s_q.stop_en))
                        ? LVMC_DEEP : LVMC_SHALLOW; //RULE15
                end
            LVMC_SHALLOW:
                if (wake_req)
                begin
                    s_d.mode = LVMC_RUN;
                end
            LVMC_DEEP:
                if (wake_req)
                begin
                    s_d.mode = LVMC_RUN;
                    s_d.deep_flag = 1'b1; //RULE10
                    s_d.irq_stat[`LVMC_IRQ_DEEP] = 1'b1;
                end
            default: s_d.mode = LVMC_RUN;
        endcase
        s_d.irq = s_q.warn_ie && s_d.warn_flag || //RULE3
            |(s_d.irq_stat & s_d.irq_mask);
        s_d.rst_req = det_ev && s_q.rst_en; //RULE4
        s_d.det_act = s_q.det_en && (s_d.mode == LVMC_RUN || s_q.stop_en);
        // stop outputs come from their own flops, in step with the mode
        s_d.stop_sh = s_d.mode == LVMC_SHALLOW;
        s_d.stop_dp = s_d.mode == LVMC_DEEP;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q <= '0; //RULE16
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // detect select lock survives system reset, cleared only at power-on
    always_ff @(posedge clk_sys or posedge por_event)
    begin
        if (por_event)
        begin
            por_lock_q <= 1'b0; //RULE14
            por_sel_q <= `LVMC_RST_VAL;
        end
        else if (wr_b && !por_lock_q)
        begin
            por_sel_q <= reg_wdata[`LVMC_B_DET_SEL]; //RULE8
            por_lock_q <= 1'b1;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign irq = s_q.irq;
    assign detect_reset_req = s_q.rst_req;
    assign detect_active = s_q.det_act;
    assign detect_trip_select = por_sel_q; //RULE9
    assign warning_trip_select = s_q.warn_sel;
    assign reference_buffer_en = s_q.ref_buf;
    assign stop_shallow = s_q.stop_sh;
    assign stop_deep = s_q.stop_dp;

    lock_once_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_q.lock_a && wr_a |=> $stable(s_q.det_en)) //RULE13
        else $error("write-once enable changed after lock");
    warn_ack_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        warn_s |=> s_q.warn_flag) //RULE2
        else $error("warning flag cleared while warning present");
    warn_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(warn_s) |=> s_q.warn_flag) //RULE1
        else $error("warning flag not set");
    warn_irq_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_q.warn_ie && s_q.warn_flag |-> ##[0:1] irq) //RULE3
        else $error("warning interrupt missing");
    det_rst_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        detect_reset_req |-> $past(s_q.det_en) && $past(s_q.rst_en)) //RULE4
        else $error("reset without enabled detect");
    stop_det_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        stop_req && s_q.mode == LVMC_RUN && s_q.det_en && s_q.stop_en
        |=> s_q.mode == LVMC_SHALLOW) //RULE15
        else $error("deep stop entered with detector on");
    deep_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_q.mode == LVMC_DEEP && wake_req |=> s_q.deep_flag) //RULE10
        else $error("recovery flag not set");
    depth_sel_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        stop_req && s_q.mode == LVMC_RUN && !s_q.depth
        |=> stop_shallow) //RULE12
        else $error("wrong stop depth");
endmodule : lvmc_ctrl

// >>> lvmc_supply_model.sv
// behavioural supply comparators and system reset request counter
`timescale 1ns/10ps
module lvmc_supply_model
(
    input wire logic clk_sys,
    input wire logic warn_lvl,
    input wire logic detect_lvl,
    input wire logic detect_reset_req,
    output logic warn_below,
    output logic detect_below,
    output int rst_cnt
);
    logic req_q = 1'b0;
    // comparators are plain levels, unrelated to the bus clock phase
    assign #3 warn_below = warn_lvl;
    assign #3 detect_below = detect_lvl;
    initial rst_cnt = 0;
    // counts reset requests instead of resetting, so the run goes on
    always @(posedge clk_sys)
    begin
        if (detect_reset_req && !req_q)
            rst_cnt <= rst_cnt + 1;
        req_q <= detect_reset_req;
    end
endmodule : lvmc_supply_model

// >>> lvmc_ctrl_tb_top.sv
// self-checking bench for the low voltage monitor control block
`timescale 1ns/10ps
module lvmc_ctrl_tb_top;
    logic clk_sys, resetn, por_event, reg_wr, reg_rd, stop_req, wake_req;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, rd_val;
    lvmc_pkg::lvmc_byte_t reg_rdata;
    logic warn_lvl, detect_lvl, warn_below, detect_below, irq, rst_rq;
    logic det_act, det_sel, warn_sel, ref_buf, st_sh, st_dp;
    int rst_cnt, error_cnt = 0, n_tests = 0;

    lvmc_ctrl i_lvmc_ctrl(.clk_sys(clk_sys), .resetn(resetn),
        .por_event(por_event), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .warn_below(warn_below), .detect_below(detect_below),
        .stop_req(stop_req), .wake_req(wake_req), .irq(irq),
        .detect_reset_req(rst_rq), .detect_active(det_act),
        .detect_trip_select(det_sel), .warning_trip_select(warn_sel),
        .reference_buffer_en(ref_buf), .stop_shallow(st_sh),
        .stop_deep(st_dp));
    lvmc_supply_model i_lvmc_supply_model(.clk_sys(clk_sys),
        .warn_lvl(warn_lvl), .detect_lvl(detect_lvl),
        .detect_reset_req(rst_rq), .warn_below(warn_below),
        .detect_below(detect_below), .rst_cnt(rst_cnt));

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask : rd
    // polls a register; running out of tries ends the run
    task automatic wait_rd(input logic [3:0] a, input logic [7:0] m,
        input logic [7:0] e);
        int i;
        for (i = 0; i < 12 && (rd_val & m) !== e; i++)
            rd(a);
        chk(rd_val & m, e);
        if (i == 12)
            give_verdict();
    endtask : wait_rd
    task automatic wait_out(ref logic s, input logic e);
        int i;
        for (i = 0; i < 12 && s !== e; i++)
            tick(1);
        chk({7'h00, s}, {7'h00, e});
        if (i == 12)
            give_verdict();
    endtask : wait_out
    task automatic do_reset(input logic por);
        @(posedge clk_sys);
        resetn <= 1'b0;
        por_event <= por;
        tick(4);
        por_event <= 1'b0;
        resetn <= 1'b1;
        rd_val = 8'h00;
    endtask : do_reset
    task automatic stop_wake(input logic wake);
        @(posedge clk_sys);
        stop_req <= ~wake;
        wake_req <= wake;
        @(posedge clk_sys);
        stop_req <= 1'b0;
        wake_req <= 1'b0;
    endtask : stop_wake

    task automatic t_reset;
        rd(0); chk(rd_val, 8'h00);
        rd(5); chk(rd_val, 8'h00);
        detect_lvl <= 1'b1;
        tick(8); chk({det_act, rst_rq, irq}, 3'h0);
        detect_lvl <= 1'b0;
        tick(8);
        $display("reset test done");
    endtask : t_reset
    task automatic t_warn;
        warn_lvl <= 1'b1;
        wait_rd(0, 8'h80, 8'h80);
        chk({7'h00, irq}, 8'h00);
        wr(0, 8'h40);
        rd(0); chk(rd_val, 8'h80);
        wr(0, 8'h20);
        tick(2); chk({7'h00, irq}, 8'h01);
        warn_lvl <= 1'b0;
        tick(8);
        wr(0, 8'h40);
        rd(0); chk(rd_val, 8'h00);
        rd(2); chk(rd_val & 8'h01, 8'h01);
        tick(2); chk({7'h00, irq}, 8'h00);
        wr(3, 8'h01);
        tick(2); chk({7'h00, irq}, 8'h01);
        wr(2, 8'h01);
        tick(2); chk({7'h00, irq}, 8'h00);
        $display("warning test done");
    endtask : t_warn
    task automatic t_once_a;
        wr(0, 8'h15);
        tick(2); chk({6'h00, ref_buf, det_act}, 8'h03);
        wr(0, 8'h00);
        rd(0); chk(rd_val, 8'h14);
        tick(1); chk({7'h00, ref_buf}, 8'h00);
        stop_wake(1'b0);
        wait_out(st_sh, 1'b1);
        chk({7'h00, det_act}, 8'h00);
        stop_wake(1'b1);
        detect_lvl <= 1'b1;
        wait_out(rst_rq, 1'b1);
        tick(1);
        chk(rst_cnt[7:0], 8'h01);
        detect_lvl <= 1'b0;
        tick(8);
        $display("control a test done");
    endtask : t_once_a
    task automatic t_once_b;
        wr(1, 8'h31);
        tick(2); chk({6'h00, det_sel, warn_sel}, 8'h03);
        wr(1, 8'h00);
        rd(1); chk(rd_val, 8'h21);
        tick(1); chk({7'h00, warn_sel}, 8'h00);
        stop_wake(1'b0);
        wait_out(st_dp, 1'b1);
        stop_wake(1'b1);
        wait_rd(1, 8'h08, 8'h08);
        wr(1, 8'h04);
        rd(1); chk(rd_val & 8'h08, 8'h00);
        do_reset(1'b0);
        wr(1, 8'h00);
        rd(1); chk(rd_val, 8'h20);
        $display("control b test done");
    endtask : t_once_b
    task automatic t_deep_veto;
        wr(0, 8'h0c);
        wr(1, 8'h01);
        stop_wake(1'b0);
        wait_out(st_sh, 1'b1);
        chk({6'h00, st_dp, det_act}, 8'h01);
        stop_wake(1'b1);
        $display("deep stop veto test done");
    endtask : t_deep_veto

    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial
    begin
        {resetn, reg_wr, reg_rd, stop_req, wake_req} = 5'h00;
        {warn_lvl, detect_lvl, reg_addr, reg_wdata} = 14'h0000;
        por_event = 1'b1;
        rd_val = 8'h00;
        do_reset(1'b1);
        t_reset();
        t_warn();
        do_reset(1'b0);
        t_once_a();
        do_reset(1'b0);
        t_once_b();
        do_reset(1'b1);
        t_deep_veto();
        give_verdict();
    end
endmodule : lvmc_ctrl_tb_top
